// File: scg_pkg.sv
// Package with register map, field layout and types of the sleep clock gating block.
package scg_pkg;
	localparam int unsigned ADDR_W = 12;
	// Register byte offsets.
	localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
	localparam logic [11:0] IRQ_STAT_OFS   = 12'h180;
	localparam logic [11:0] IRQ_CLR_OFS    = 12'h184;
	localparam logic [11:0] IRQ_EN_OFS     = 12'h188;
	localparam logic [11:0] FAULT_INFO_OFS = 12'h18C;
	localparam logic [11:0] ACTIVE_OFS     = 12'h190;
	// Gating bit positions.
	localparam int unsigned ANALOG_CMP0_BIT   = 24;
	localparam int unsigned GP_COUNTER0_BIT   = 16;
	localparam int unsigned TWO_WIRE0_BIT     = 12;
	localparam int unsigned QUAD_DEC0_BIT     = 8;
	localparam int unsigned SYNC_SERIAL0_BIT  = 4;
	localparam int unsigned ASYNC_SERIAL0_BIT = 0;
	// Writable gating bits; every other bit is reserved and reads zero.
	localparam logic [31:0] GATE_MASK  = 32'h070F_1137;
	localparam logic [31:0] GATE_RESET = 32'h0000_0000;
	// Interrupt status bit positions.
	localparam int unsigned EV_FAULT_BIT = 0;
	localparam int unsigned EV_SLEEP_BIT = 1;
	localparam int unsigned EV_WAKE_BIT  = 2;
	localparam int unsigned EV_W         = 3;
	localparam logic [2:0]  IRQ_RESET    = 3'h0;
	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power mode, one-hot.
	typedef enum logic [2:0] {
		SCG_RUN   = 3'b001,
		SCG_SLEEP = 3'b010,
		SCG_DEEP  = 3'b100
	} scg_mode_t;
	// Last faulted access: valid flag and unit index.
	typedef struct packed {
		logic       seen;
		logic [4:0] unit;
	} scg_fault_t;
	// Held write request of the register bus.
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
		logic [3:0]  strb;
	} scg_wreq_t;
endpackage

// File: scg_sleep_gate.sv
// Sleep-mode peripheral clock gating register with AXI4-Lite access and fault check.
// Operation
// RQ1: A set gating bit clocks its unit; a clear bit leaves it unclocked.
// RQ2: Access to a unit whose clock is gated off answers with a bus fault.
// RQ3: Reset clears every gating bit; register reads 0x00000000, all units off.
// RQ4: Run, sleep and deep sleep use separate gating sets; this one is sleep.
// RQ5: Sleep gating applies only while automatic clock gating select is set.
// RQ6: Bits 26, 25, 24 gate analog comparators 2, 1, 0.
// RQ7: Bits 19 to 16 gate general-purpose counters 3 to 0.
// RQ8: Bit 12 gates two-wire serial unit 0.
// RQ9: Bit 8 gates quadrature decoder 0.
// RQ10: Bit 5 gates synchronous serial unit 1.
// RQ11: Bit 4 gates synchronous serial unit 0.
// RQ12: Bits 2, 1, 0 gate asynchronous serial units 2, 1, 0.
// RQ13: Reserved bits are read-only and read zero.
// RQ14: Software should preserve reserved bits in read-modify-write updates.
// RQ15: Software must enable every unit it needs; none runs after reset.
// RQ16: Writes to reserved bits are silently ignored and leave them zero.
// RQ17: Outside sleep this register affects no clock but stays accessible.
module scg_sleep_gate (
	// Clock and reset.
	input  wire logic        MCLK,
	input  wire logic        RST_N,
	// AXI4-Lite write address and data.
	input  wire logic [11:0] AWADDR,
	input  wire logic        AWVALID,
	output logic             AWREADY,
	input  wire logic [31:0] WDATA,
	input  wire logic [3:0]  WSTRB,
	input  wire logic        WVALID,
	output logic             WREADY,
	// AXI4-Lite write response.
	output logic [1:0]       BRESP,
	output logic             BVALID,
	input  wire logic        BREADY,
	// AXI4-Lite read.
	input  wire logic [11:0] ARADDR,
	input  wire logic        ARVALID,
	output logic             ARREADY,
	output logic [31:0]      RDATA,
	output logic [1:0]       RRESP,
	output logic             RVALID,
	input  wire logic        RREADY,
	// Power controller and neighbouring gating registers.
	input  wire logic        SLEEP_REQ,
	input  wire logic        DEEP_REQ,
	input  wire logic        AUTO_CLOCK_GATING_SELECT,
	input  wire logic [31:0] RUN_MODE_CLOCK_GATING_1,
	input  wire logic [31:0] DEEP_SLEEP_CLOCK_GATING_1,
	// Peripheral access check from the system bus.
	input  wire logic        PERIPH_REQ,
	input  wire logic [4:0]  PERIPH_UNIT,
	output logic             BUS_FAULT,
	// Unit clock enables and interrupt.
	output logic [31:0]      UNIT_CLK_EN,
	output logic             IRQ
);
	// Merge write data into a word under byte strobes.
	function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] res;
		res = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				res[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return res;
	endfunction

	// Word-aligned address compare.
	function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
		return a[11:2] == ofs[11:2];
	endfunction

	logic [31:0]         sleep_gate_reg;
	logic [31:0]         active_reg;
	logic [2:0]          irq_stat_reg;
	logic [2:0]          irq_en_reg;
	logic [2:0]          irq_clr_next;
	logic [2:0]          events;
	scg_pkg::scg_mode_t  mode_reg;
	scg_pkg::scg_mode_t  mode_next;
	scg_pkg::scg_fault_t fault_reg;
	scg_pkg::scg_wreq_t  wreq_reg;
	logic                aw_full_reg;
	logic                w_full_reg;
	logic                bvalid_reg;
	logic [1:0]          bresp_reg;
	logic                rvalid_reg;
	logic [1:0]          rresp_reg;
	logic [31:0]         rdata_reg;
	logic                bus_fault_reg;
	logic                do_write;
	logic [31:0]         gate_next;

	// Write address and data are taken independently, in either order.
	assign AWREADY  = !aw_full_reg && !bvalid_reg;
	assign WREADY   = !w_full_reg && !bvalid_reg;
	assign do_write = aw_full_reg && w_full_reg && !bvalid_reg;
	assign ARREADY  = !rvalid_reg;
	assign BVALID   = bvalid_reg;
	assign BRESP    = bresp_reg;
	assign RVALID   = rvalid_reg;
	assign RRESP    = rresp_reg;
	assign RDATA    = rdata_reg;

	// Both halves land in one held request, so one process owns it. A half is refused while
	// it is held or a response waits, so a capture never meets the write of the same request.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			aw_full_reg   <= 1'b0;
			w_full_reg    <= 1'b0;
			wreq_reg.addr <= 12'h000;
			wreq_reg.data <= 32'h0000_0000;
			wreq_reg.strb <= 4'h0;
		end else begin
			if (AWVALID && AWREADY) begin
				aw_full_reg   <= 1'b1;
				wreq_reg.addr <= AWADDR;
			end else if (do_write) begin
				aw_full_reg <= 1'b0;
			end
			if (WVALID && WREADY) begin
				w_full_reg    <= 1'b1;
				wreq_reg.data <= WDATA;
				wreq_reg.strb <= WSTRB;
			end else if (do_write) begin
				w_full_reg <= 1'b0;
			end
		end
	end

	// Write response; unmapped or read-only targets answer SLVERR.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			bvalid_reg <= 1'b0;
			bresp_reg  <= scg_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_reg <= 1'b1;
			if (hit(wreq_reg.addr, scg_pkg::SLEEP_GATE_OFS)) begin
				bresp_reg <= scg_pkg::RESP_OKAY;
			end else if (hit(wreq_reg.addr, scg_pkg::IRQ_CLR_OFS)) begin
				bresp_reg <= scg_pkg::RESP_OKAY;
			end else if (hit(wreq_reg.addr, scg_pkg::IRQ_EN_OFS)) begin
				bresp_reg <= scg_pkg::RESP_OKAY;
			end else begin
				bresp_reg <= scg_pkg::RESP_SLVERR;
			end
		end else if (BREADY) begin
			bvalid_reg <= 1'b0;
		end
	end

	// Reserved bits are masked off, so writes to them vanish without error.
	assign gate_next = merge_bytes(sleep_gate_reg, wreq_reg.data, wreq_reg.strb)
		& scg_pkg::GATE_MASK; // RQ13 RQ16

	// Sleep gating register; stays writable in every mode.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			sleep_gate_reg <= scg_pkg::GATE_RESET; // RQ3
		end else if (do_write && hit(wreq_reg.addr, scg_pkg::SLEEP_GATE_OFS)) begin
			sleep_gate_reg <= gate_next; // RQ6 RQ7 RQ8 RQ9 RQ10 RQ11 RQ12 RQ17
		end
	end

	// Only byte lane zero carries enable bits, so writes through other lanes are ignored.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			irq_en_reg <= scg_pkg::IRQ_RESET;
		end else if (do_write && hit(wreq_reg.addr, scg_pkg::IRQ_EN_OFS) && wreq_reg.strb[0]) begin
			irq_en_reg <= wreq_reg.data[2:0];
		end
	end

	// A clear lasts only the cycle in which its write is carried out.
	always_comb begin
		irq_clr_next = 3'h0;
		if (do_write && hit(wreq_reg.addr, scg_pkg::IRQ_CLR_OFS) && wreq_reg.strb[0]) begin
			irq_clr_next = wreq_reg.data[2:0];
		end
	end

	// Read channel; unmapped addresses answer SLVERR with zero data.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			rvalid_reg <= 1'b0;
			rresp_reg  <= scg_pkg::RESP_OKAY;
			rdata_reg  <= 32'h0000_0000;
		end else if (ARVALID && ARREADY) begin
			rvalid_reg <= 1'b1;
			rresp_reg  <= scg_pkg::RESP_OKAY;
			if (hit(ARADDR, scg_pkg::SLEEP_GATE_OFS)) begin
				rdata_reg <= sleep_gate_reg; // RQ13
			end else if (hit(ARADDR, scg_pkg::IRQ_STAT_OFS)) begin
				rdata_reg <= {29'h0000_0000, irq_stat_reg};
			end else if (hit(ARADDR, scg_pkg::IRQ_EN_OFS)) begin
				rdata_reg <= {29'h0000_0000, irq_en_reg};
			end else if (hit(ARADDR, scg_pkg::FAULT_INFO_OFS)) begin
				rdata_reg <= {26'h000_0000, fault_reg};
			end else if (hit(ARADDR, scg_pkg::ACTIVE_OFS)) begin
				rdata_reg <= active_reg;
			end else if (hit(ARADDR, scg_pkg::IRQ_CLR_OFS)) begin
				rdata_reg <= 32'h0000_0000;
			end else begin
				rdata_reg <= 32'h0000_0000;
				rresp_reg <= scg_pkg::RESP_SLVERR;
			end
		end else if (RREADY) begin
			rvalid_reg <= 1'b0;
		end
	end

	// Power mode tracking; deep sleep is only reached through a sleep request.
	always_comb begin
		mode_next = scg_pkg::SCG_RUN;
		if (SLEEP_REQ && DEEP_REQ) begin
			mode_next = scg_pkg::SCG_DEEP;
		end else if (SLEEP_REQ) begin
			mode_next = scg_pkg::SCG_SLEEP;
		end
	end

	// Mode is registered once, so the enables follow a mode change two edges later.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			mode_reg <= scg_pkg::SCG_RUN;
		end else begin
			mode_reg <= mode_next;
		end
	end

	// Pick the gating set of the current mode. Without automatic gating the
	// run set stays in force during sleep, so the sleep set does nothing.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			active_reg <= scg_pkg::GATE_RESET; // RQ3
		end else begin
			case (mode_reg)
				scg_pkg::SCG_SLEEP: begin
					if (AUTO_CLOCK_GATING_SELECT) begin
						active_reg <= sleep_gate_reg; // RQ4 RQ5
					end else begin
						active_reg <= RUN_MODE_CLOCK_GATING_1 & scg_pkg::GATE_MASK;
					end
				end
				scg_pkg::SCG_DEEP: begin
					if (AUTO_CLOCK_GATING_SELECT) begin
						active_reg <= DEEP_SLEEP_CLOCK_GATING_1 & scg_pkg::GATE_MASK; // RQ4
					end else begin
						active_reg <= RUN_MODE_CLOCK_GATING_1 & scg_pkg::GATE_MASK;
					end
				end
				default: begin
					active_reg <= RUN_MODE_CLOCK_GATING_1 & scg_pkg::GATE_MASK; // RQ17
				end
			endcase
		end
	end

	// Enables feed the clock gate cells of each unit, one bit per unit.
	assign UNIT_CLK_EN = active_reg; // RQ1

	// An access to an unclocked unit faults; reserved unit indices always fault.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			bus_fault_reg  <= 1'b0;
			fault_reg.seen <= 1'b0;
			fault_reg.unit <= 5'h00;
		end else begin
			bus_fault_reg <= PERIPH_REQ && !active_reg[PERIPH_UNIT]; // RQ2
			if (PERIPH_REQ && !active_reg[PERIPH_UNIT]) begin
				fault_reg.seen <= 1'b1;
				fault_reg.unit <= PERIPH_UNIT;
			end
		end
	end

	assign BUS_FAULT = bus_fault_reg;

	// Events are the one-cycle causes of the sticky status bits.
	always_comb begin
		events = 3'h0;
		events[scg_pkg::EV_FAULT_BIT] = PERIPH_REQ && !active_reg[PERIPH_UNIT];
		events[scg_pkg::EV_SLEEP_BIT] = (mode_reg == scg_pkg::SCG_RUN)
			&& (mode_next != scg_pkg::SCG_RUN);
		events[scg_pkg::EV_WAKE_BIT]  = (mode_reg != scg_pkg::SCG_RUN)
			&& (mode_next == scg_pkg::SCG_RUN);
	end

	// A new event in the clearing cycle survives the clear.
	always_ff @(posedge MCLK) begin
		if (!RST_N) begin
			irq_stat_reg <= scg_pkg::IRQ_RESET;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr_next) | events;
		end
	end

	// Level interrupt, high while any enabled status bit is set.
	assign IRQ = |(irq_stat_reg & irq_en_reg);
endmodule // scg_sleep_gate

// File: scg_sleep_gate_asserts.sv
// Port checker of the sleep clock gating block.
module scg_sleep_gate_asserts (
	// Clock and reset.
	input wire logic        MCLK,
	input wire logic        RST_N,
	// Mode inputs and outside gating sets.
	input wire logic        SLEEP_REQ,
	input wire logic        DEEP_REQ,
	input wire logic        AUTO_CLOCK_GATING_SELECT,
	input wire logic [31:0] RUN_MODE_CLOCK_GATING_1,
	input wire logic [31:0] DEEP_SLEEP_CLOCK_GATING_1,
	// Peripheral access and results.
	input wire logic        PERIPH_REQ,
	input wire logic [4:0]  PERIPH_UNIT,
	input wire logic        BUS_FAULT,
	input wire logic [31:0] UNIT_CLK_EN
);
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// Three steady samples cover the two-edge latency of a mode change.
	sequence run_steady;
		(!SLEEP_REQ && $stable(RUN_MODE_CLOCK_GATING_1)) [*3];
	endsequence
	sequence sleep_manual;
		(SLEEP_REQ && !AUTO_CLOCK_GATING_SELECT && $stable(RUN_MODE_CLOCK_GATING_1)) [*3];
	endsequence
	sequence deep_auto;
		(SLEEP_REQ && DEEP_REQ && AUTO_CLOCK_GATING_SELECT
			&& $stable(DEEP_SLEEP_CLOCK_GATING_1)) [*3];
	endsequence
	a_fault_gated: assert property (PERIPH_REQ && !UNIT_CLK_EN[PERIPH_UNIT] |=> BUS_FAULT)
		else $error("access to a gated unit gave no fault");
	a_fault_clocked: assert property (PERIPH_REQ && UNIT_CLK_EN[PERIPH_UNIT] |=> !BUS_FAULT)
		else $error("access to a clocked unit faulted");
	a_fault_cause: assert property (BUS_FAULT |-> $past(PERIPH_REQ))
		else $error("fault without an access");
	a_reserved_zero: assert property ((UNIT_CLK_EN & ~scg_pkg::GATE_MASK) == 32'h0)
		else $error("reserved clock enable set");
	a_reset_clear: assert property ($rose(RST_N) |-> UNIT_CLK_EN == 32'h0 && !BUS_FAULT)
		else $error("enables not cleared by reset");
	a_run_set: assert property (run_steady |-> UNIT_CLK_EN ==
		(RUN_MODE_CLOCK_GATING_1 & scg_pkg::GATE_MASK)) else $error("run set not applied");
	a_sleep_manual: assert property (sleep_manual |-> UNIT_CLK_EN ==
		(RUN_MODE_CLOCK_GATING_1 & scg_pkg::GATE_MASK)) else $error("manual sleep left run set");
	a_deep_set: assert property (deep_auto |-> UNIT_CLK_EN ==
		(DEEP_SLEEP_CLOCK_GATING_1 & scg_pkg::GATE_MASK)) else $error("deep set not applied");
endmodule // scg_sleep_gate_asserts

bind scg_sleep_gate scg_sleep_gate_asserts chk_i (.*);

// File: scg_periph_model.sv
// Model of the system bus side that touches peripheral units.
module scg_periph_model (
	// Clock and command from the bench.
	input wire logic       MCLK,
	input wire logic       go,
	input wire logic [4:0] unit,
	// Access toward the gating block.
	output logic           PERIPH_REQ,
	output logic [4:0]     PERIPH_UNIT
);
	timeunit 1ns;
	timeprecision 1ns;
	// Between accesses the index toggles, so a stale unit is never mistaken for a request.
	always_ff @(posedge MCLK) begin
		PERIPH_REQ <= go;
		PERIPH_UNIT <= go ? unit : ~PERIPH_UNIT;
	end
endmodule // scg_periph_model

// File: tb_sleep_clock_gating.sv
// Self-checking bench of the sleep clock gating block.
module tb_sleep_clock_gating;
	timeunit 1ns;
	timeprecision 1ns;
	logic        MCLK, RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP_REQ, DEEP_REQ;
	logic        AUTO_CLOCK_GATING_SELECT, PERIPH_REQ, go, AWREADY, WREADY, BVALID, ARREADY;
	logic        RVALID, BUS_FAULT, IRQ;
	logic [1:0]  BRESP, RRESP, resp;
	logic [3:0]  WSTRB;
	logic [4:0]  PERIPH_UNIT, unit;
	logic [11:0] AWADDR, ARADDR;
	logic [31:0] WDATA, RDATA, RUN_MODE_CLOCK_GATING_1, DEEP_SLEEP_CLOCK_GATING_1, UNIT_CLK_EN, rd, v;
	int          fails, total_checks;
	int          bits[14] = '{26, 25, 24, 19, 18, 17, 16, 12, 8, 5, 4, 2, 1, 0};
	scg_sleep_gate uut (.*);
	scg_periph_model pm (.*);
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic end_sim;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge MCLK);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		for (n = 0; n < 50 && !BVALID; n++) begin
			@(posedge MCLK);
			if (AWREADY)
				AWVALID <= 1'b0;
			if (WREADY)
				WVALID <= 1'b0;
		end
		resp = BRESP;
		BREADY <= 1'b0;
		if (n == 50) begin
			fails++;
			end_sim();
		end
	endtask
	task automatic rdw(input logic [11:0] a);
		int n;
		@(posedge MCLK);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		for (n = 0; n < 50 && !RVALID; n++) begin
			@(posedge MCLK);
			if (ARREADY)
				ARVALID <= 1'b0;
		end
		rd = RDATA;
		resp = RRESP;
		RREADY <= 1'b0;
		if (n == 50) begin
			fails++;
			end_sim();
		end
	endtask
	// The partner issues the access one edge after the command; the fault pulse stands for one
	// cycle after the next edge, so it is looked at just after that edge.
	task automatic touch(input logic [4:0] u, input logic f);
		@(posedge MCLK);
		go <= 1'b1;
		unit <= u;
		@(posedge MCLK);
		go <= 1'b0;
		@(posedge MCLK);
		#1;
		chk("bus_fault", {31'h0, f}, {31'h0, BUS_FAULT});
	endtask
	task automatic mode(input logic s, input logic d, input logic a, input logic [31:0] exp);
		@(posedge MCLK);
		SLEEP_REQ <= s;
		DEEP_REQ <= d;
		AUTO_CLOCK_GATING_SELECT <= a;
		repeat (3) @(posedge MCLK);
		#1;
		chk("unit_clk_en", exp, UNIT_CLK_EN);
	endtask
	initial begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end
	initial begin
		{RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, SLEEP_REQ, DEEP_REQ, go} = 9'h0;
		{AUTO_CLOCK_GATING_SELECT, unit, AWADDR, ARADDR, WDATA} = 62'h0;
		WSTRB = 4'hF;
		RUN_MODE_CLOCK_GATING_1 = 32'h0000_1111;
		DEEP_SLEEP_CLOCK_GATING_1 = 32'h0500_0022;
		repeat (10) @(posedge MCLK);
		RST_N <= 1'b1;
		rdw(scg_pkg::SLEEP_GATE_OFS);
		chk("gate_reset", 32'h0, rd);
		rdw(12'h7F0);
		chk("unmapped_resp", 32'h2, {30'h0, resp});
		mode(1'b1, 1'b0, 1'b1, 32'h0);
		touch(5'h10, 1'b1);
		foreach (bits[i]) begin
			v = 32'h1 << bits[i];
			wr(scg_pkg::SLEEP_GATE_OFS, v);
			repeat (2) @(posedge MCLK);
			#1;
			chk("unit_clk_en", v, UNIT_CLK_EN);
			rdw(scg_pkg::SLEEP_GATE_OFS);
			chk("gate_bit", v, rd);
			touch(5'(bits[i]), 1'b0);
		end
		wr(scg_pkg::SLEEP_GATE_OFS, 32'hFFFF_FFFF);
		chk("gate_wr_resp", 32'h0, {30'h0, resp});
		rdw(scg_pkg::SLEEP_GATE_OFS);
		chk("gate_all", 32'h070F_1137, rd);
		wr(scg_pkg::SLEEP_GATE_OFS, rd & ~32'h0000_0001);
		mode(1'b0, 1'b0, 1'b1, 32'h0000_1111);
		mode(1'b1, 1'b0, 1'b0, 32'h0000_1111);
		mode(1'b1, 1'b1, 1'b1, 32'h0500_0022);
		mode(1'b1, 1'b0, 1'b1, 32'h070F_1136);
		wr(scg_pkg::IRQ_CLR_OFS, 32'h0000_0007);
		wr(scg_pkg::IRQ_EN_OFS, 32'h0000_0001);
		touch(5'h3, 1'b1);
		chk("irq_set", 32'h1, {31'h0, IRQ});
		rdw(scg_pkg::IRQ_STAT_OFS);
		chk("irq_status", 32'h1, rd & 32'h1);
		rdw(scg_pkg::FAULT_INFO_OFS);
		chk("fault_info", 32'h0000_0023, rd);
		rdw(scg_pkg::ACTIVE_OFS);
		chk("active_read", 32'h070F_1136, rd);
		wr(scg_pkg::IRQ_STAT_OFS, 32'h0000_0001);
		chk("ro_wr_resp", 32'h2, {30'h0, resp});
		wr(scg_pkg::IRQ_CLR_OFS, 32'h0000_0001);
		chk("irq_clear", 32'h0, {31'h0, IRQ});
		wr(scg_pkg::IRQ_EN_OFS, 32'h0);
		touch(5'h3, 1'b1);
		chk("irq_mask", 32'h0, {31'h0, IRQ});
		@(posedge MCLK);
		RST_N <= 1'b0;
		@(posedge MCLK);
		RST_N <= 1'b1;
		rdw(scg_pkg::SLEEP_GATE_OFS);
		chk("gate_rereset", 32'h0, rd);
		end_sim();
	end
endmodule // tb_sleep_clock_gating
